//--- src/lcd_port_device.sv
`timescale 1ns/1ns
`include "lcd_port_map.svh"
// How it works
// (RULE_01) Strap high selects the parallel port.
// (RULE_02) Parallel bus is eight or four lines.
// (RULE_03) Width bit one means eight, zero four.
// (RULE_04) Host drives select, direction, strobe, data.
// (RULE_05) Four-line bytes move as two transfers.
// (RULE_06) Upper nibble first, on upper lines.
// (RULE_07) Lower nibble second, upper lines; lower ignored.
// (RULE_08) Strap low selects the two-line serial link.
// (RULE_09) Serial link carries writes only.
// (RULE_10) Serial clock counts only while select high.
// (RULE_11) Select low aborts and clears serial reception.
// (RULE_12) Single device: select tied high permanently.
// (RULE_13) Host makes serial clock; device resynchronises.
// (RULE_14) Host waits for previous instruction to finish.
// (RULE_15) Busy device refuses new instructions.
// (RULE_16) Five ones start and resync every frame.
// (RULE_17) Sync, then direction, select, four zeros.
// (RULE_18) Each byte: two nibble groups zero padded.
// (RULE_19) MSB first, sampled on rising serial clock.
module lcd_port_device
  import lcd_port_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  lcd_host_if.dev         link,
  input  wire logic       busy_i,
  input  wire logic [6:0] addr_i,
  input  wire logic [7:0] ram_data_i,
  output logic            wr_valid_o,
  output logic            wr_rs_o,
  output logic [7:0]      wr_data_o,
  output logic            refused_o,
  output logic            bus_width_o,
  output logic            serial_mode_o
);
  // Serial receiver state; cleared whenever chip select drops.
  typedef struct packed {
    logic [2:0] ones;
    logic       in_frame;
    logic [4:0] pos;
    logic       rw;
    logic       rs;
    logic [7:0] data;
  } rx_state_type;

  // Hand-over to the core clock; only the system reset clears it, so that a chip-select
  // abort never looks like a finished byte on the other side.
  typedef struct packed {
    logic       tog;
    logic       cap_rs;
    logic [7:0] cap_data;
  } hand_state_type;

  typedef struct packed {
    logic       e_prev;
    logic       tog_prev;
    logic       dl;
    logic       nib_phase;
    logic [3:0] hi_nib;
    logic       db_oe;
    logic [7:0] db_out;
    logic       wr_valid;
    logic       wr_rs;
    logic [7:0] wr_data;
    logic       refused;
    logic       serial_mode;
  } dev_state_type;

  rx_state_type   rx;
  rx_state_type   next_rx;
  hand_state_type hand;
  hand_state_type next_hand;
  dev_state_type  st;
  dev_state_type  next_st;

  logic       link_rst_n;
  logic [12:0] pins_sync;
  logic       s_strap;
  logic       s_e;
  logic       s_rs;
  logic       s_rw;
  logic [7:0] s_db;
  logic       s_tog;

  // Serial clock domain.
  assign link_rst_n = arst_n_i & link.cs; // [RULE_10] [RULE_11]

  always_comb begin
    next_rx   = rx;
    next_hand = hand;
    next_rx.ones = link.serial_data_input ? ((rx.ones == `ONES_MAX) ? rx.ones : rx.ones + 3'h1) : 3'h0;
    if (link.serial_data_input && rx.ones == `SYNC_RUN_LAST) begin
      // A run of five ones cannot occur inside padded nibbles, so it always marks a new frame.
      next_rx.in_frame = 1'b1; // [RULE_16]
      next_rx.pos      = `SER_POS_RW;
      next_rx.data     = '0;
    end else if (rx.in_frame) begin
      next_rx.pos = rx.pos + 5'h01;
      if (rx.pos == `SER_POS_RW) begin
        next_rx.rw = link.serial_data_input; // [RULE_17]
      end
      if (rx.pos == `SER_POS_RS) begin
        next_rx.rs = link.serial_data_input; // [RULE_17]
      end
      if ((rx.pos >= `SER_POS_HI && rx.pos <= `SER_POS_HI_END) ||
          (rx.pos >= `SER_POS_LO && rx.pos <= `SER_POS_LO_END)) begin
        next_rx.data = {rx.data[6:0], link.serial_data_input}; // [RULE_18] [RULE_19]
      end
      if (rx.pos == `SER_POS_END) begin
        next_rx.in_frame = 1'b0;
        if (!rx.rw) begin // [RULE_09]
          next_hand.tog      = ~hand.tog;
          next_hand.cap_rs   = rx.rs;
          next_hand.cap_data = rx.data;
        end
      end
    end
  end

  always_ff @(posedge link.sclk or negedge link_rst_n) begin // [RULE_19]
    if (!link_rst_n) begin
      rx <= '0; // [RULE_11]
    end else begin
      rx <= next_rx;
    end
  end

  always_ff @(posedge link.sclk or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hand <= '0;
    end else begin
      hand <= next_hand;
    end
  end

  // Core clock domain: the strap, the parallel pins and the hand-over toggle pass two flip-flops.
  bit_sync #(
    .WIDTH (13)
  ) u_pin_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .async_i  ({link.strap, link.e, link.rs, link.rw, link.db, hand.tog}), // [RULE_13]
    .sync_o   (pins_sync)
  );

  assign {s_strap, s_e, s_rs, s_rw, s_db, s_tog} = pins_sync;

  always_comb begin
    logic       have_byte;
    logic       byte_rs;
    logic [7:0] byte_val;
    logic [7:0] rd_byte;
    have_byte = 1'b0;
    byte_rs   = 1'b0;
    byte_val  = '0;
    rd_byte   = s_rs ? ram_data_i : {busy_i, addr_i};
    next_st          = st;
    next_st.e_prev   = s_e;
    next_st.tog_prev = s_tog;
    next_st.wr_valid = 1'b0;
    next_st.refused  = 1'b0;
    next_st.serial_mode = !s_strap; // [RULE_01] [RULE_08]

    // Read data is driven only while the strobe is high in parallel mode.
    if (s_strap && s_e && s_rw) begin
      next_st.db_oe  = 1'b1;
      next_st.db_out = place_nibble(st.dl, st.nib_phase, rd_byte); // [RULE_06] [RULE_07]
    end else begin
      next_st.db_oe  = 1'b0;
    end

    if (s_strap && st.e_prev && !s_e) begin // [RULE_04]
      if (st.dl) begin // [RULE_02]
        if (!s_rw) begin
          have_byte = 1'b1;
          byte_rs   = s_rs;
          byte_val  = s_db;
        end
      end else begin
        next_st.nib_phase = ~st.nib_phase; // [RULE_05]
        if (!s_rw) begin
          if (!st.nib_phase) begin
            next_st.hi_nib = s_db[`NIB_HI]; // [RULE_06]
          end else begin
            have_byte = 1'b1;
            byte_rs   = s_rs;
            byte_val  = {st.hi_nib, s_db[`NIB_HI]}; // [RULE_07]
          end
        end
      end
    end

    if (!s_strap && s_tog != st.tog_prev) begin // [RULE_13]
      have_byte = 1'b1;
      byte_rs   = hand.cap_rs;
      byte_val  = hand.cap_data;
    end

    if (!s_strap) begin
      next_st.nib_phase = 1'b0;
    end

    if (have_byte) begin
      if (busy_i) begin
        next_st.refused = 1'b1; // [RULE_15]
      end else begin
        next_st.wr_valid = 1'b1;
        next_st.wr_rs    = byte_rs;
        next_st.wr_data  = byte_val;
        if (is_function_set(byte_rs, byte_val)) begin
          next_st.dl        = byte_val[`FS_DL_BIT]; // [RULE_03]
          next_st.nib_phase = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st    <= '0;
      st.dl <= `DL_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign link.db_dev    = st.db_out;
  assign link.db_dev_oe = st.db_oe;
  assign wr_valid_o     = st.wr_valid;
  assign wr_rs_o        = st.wr_rs;
  assign wr_data_o      = st.wr_data;
  assign refused_o      = st.refused;
  assign bus_width_o    = st.dl;
  assign serial_mode_o  = st.serial_mode;
endmodule

//--- src/lcd_port_map.svh
`ifndef LCD_PORT_MAP_SVH
`define LCD_PORT_MAP_SVH

// Clock period of both ends, in ns.
`define CLK_NS 50

// Host-side parallel timing, in ns.
`define T_AS_NS 10
`define T_PW_NS 500
`define T_CYC_NS 1200

// Time the host leaves between two writes so that the previous one can finish, in ns.
`define T_EXEC_NS 72000

// Half period of the serial clock made by the host, in ns.
`define T_SCLK_HALF_NS 400

`define CYC_UP(ns) (((ns) + `CLK_NS - 1) / `CLK_NS)
`define CYC_DN(ns) ((ns) / `CLK_NS)

// Function-set instruction layout.
`define FS_OP_HI 7
`define FS_OP_LO 5
`define FS_DL_BIT 4
`define FUNC_SET_OP 3'h1
`define DL_RESET 1'h1

// Nibble placement on the data lines.
`define NIB_HI 7:4
`define NIB_LO 3:0
`define PAD_NIBBLE 4'h0

// Serial framing.
`define SYNC_PATTERN 5'h1f
`define SYNC_RUN_LAST 3'h4
`define ONES_MAX 3'h7
`define SYNC_ZEROS 4'h0
`define FRAME_BITS 5'h1b
`define SER_POS_RW 5'h00
`define SER_POS_RS 5'h01
`define SER_POS_HI 5'h06
`define SER_POS_HI_END 5'h09
`define SER_POS_LO 5'h0e
`define SER_POS_LO_END 5'h11
`define SER_POS_END 5'h15

`endif

//--- src/lcd_port_pkg.sv
package lcd_port_pkg;
  `include "lcd_port_map.svh"

  typedef enum logic [2:0] {
    H_IDLE,
    H_SETUP,
    H_EHIGH,
    H_EHOLD,
    H_SER,
    H_GAP
  } host_state_type;

  function automatic logic is_function_set(input logic rs, input logic [7:0] value);
    return !rs && (value[`FS_OP_HI:`FS_OP_LO] == `FUNC_SET_OP);
  endfunction

  // Places a byte or one of its nibbles on the data lines; in four-line mode the nibble
  // always rides on the upper lines and the lower lines carry zeros.
  function automatic logic [7:0] place_nibble(input logic dl, input logic low_half, input logic [7:0] value);
    if (dl) begin
      return value;
    end
    return low_half ? {value[`NIB_LO], `PAD_NIBBLE} : {value[`NIB_HI], `PAD_NIBBLE};
  endfunction
endpackage

//--- src/lcd_host_if.sv
`timescale 1ns/1ns
interface lcd_host_if;
  logic       strap;
  logic       rs;
  logic       rw;
  logic       e;
  logic [7:0] db_host;
  logic       db_host_oe;
  logic [7:0] db_dev;
  logic       db_dev_oe;
  logic [7:0] db;
  logic       cs;
  logic       sclk;
  logic       serial_data_input;

  // Undriven data lines read high, as the pins have pull-ups.
  assign db = db_dev_oe ? db_dev : (db_host_oe ? db_host : 8'hff);

  modport dev (
    input  strap, rs, rw, e, db, cs, sclk, serial_data_input,
    output db_dev, db_dev_oe
  );

  modport host (
    output strap, rs, rw, e, db_host, db_host_oe, cs, sclk, serial_data_input,
    input  db
  );
endinterface

//--- src/bit_sync.sv
`timescale 1ns/1ns
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_type;

  sync_state_type state;
  sync_state_type next_state;

  always_comb begin
    next_state.meta   = async_i;
    next_state.stable = state.meta;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_o = state.stable;
endmodule

//--- src/lcd_port_host.sv
`timescale 1ns/1ns
`include "lcd_port_map.svh"
module lcd_port_host
  import lcd_port_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  lcd_host_if.host        link,
  input  wire logic       serial_mode_i,
  input  wire logic       cmd_valid_i,
  output logic            cmd_ready_o,
  input  wire logic       cmd_rs_i,
  input  wire logic       cmd_rw_i,
  input  wire logic [7:0] cmd_data_i,
  output logic            rsp_valid_o,
  output logic [7:0]      rsp_data_o,
  output logic            bus_width_o
);
  localparam logic [10:0] AS_CYC   = 11'(`CYC_UP(`T_AS_NS));
  localparam logic [10:0] PW_CYC   = 11'(`CYC_UP(`T_PW_NS));
  localparam logic [10:0] HOLD_CYC = 11'(`CYC_UP(`T_CYC_NS - `T_AS_NS - `T_PW_NS));
  localparam logic [10:0] EXEC_CYC = 11'(`CYC_UP(`T_EXEC_NS));
  localparam logic [10:0] HALF_CYC = 11'(`CYC_DN(`T_SCLK_HALF_NS));

  typedef struct packed {
    host_state_type st;
    logic [10:0]    cnt;
    logic           rs;
    logic           rw;
    logic [7:0]     data;
    logic           phase;
    logic           dl;
    logic           serial;
    logic [26:0]    frame;
    logic [4:0]     bits;
    logic           e;
    logic           sclk;
    logic           serial_data_input;
    logic [7:0]     db_out;
    logic           db_oe;
    logic           rsp_valid;
    logic [7:0]     rsp_data;
    logic [3:0]     hi_rd;
  } host_reg_type;

  host_reg_type r;
  host_reg_type next_r;
  logic [7:0]   db_s;

  bit_sync #(
    .WIDTH (8)
  ) u_db_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .async_i  (link.db),
    .sync_o   (db_s)
  );

  always_comb begin
    next_r           = r;
    next_r.rsp_valid = 1'b0;
    if (r.cnt != 11'h000) begin
      next_r.cnt = r.cnt - 11'h001;
    end
    case (r.st)
      H_IDLE: begin
        if (cmd_valid_i) begin
          next_r.rs     = cmd_rs_i;
          next_r.rw     = cmd_rw_i;
          next_r.data   = cmd_data_i;
          next_r.serial = serial_mode_i;
          next_r.phase  = 1'b0;
          if (serial_mode_i) begin
            // A read cannot travel over the serial link; it is taken and dropped.
            if (!cmd_rw_i) begin // [RULE_09]
              next_r.frame = {`SYNC_PATTERN, cmd_rw_i, cmd_rs_i, `SYNC_ZEROS, cmd_data_i[`NIB_HI], `PAD_NIBBLE,
                              cmd_data_i[`NIB_LO], `PAD_NIBBLE};
              next_r.serial_data_input   = next_r.frame[26]; // [RULE_16] [RULE_19]
              next_r.bits  = `FRAME_BITS;
              next_r.cnt   = HALF_CYC - 11'h001;
              next_r.st    = H_SER;
            end
          end else begin
            next_r.db_out = place_nibble(r.dl, 1'b0, cmd_data_i);
            next_r.db_oe  = !cmd_rw_i;
            next_r.cnt    = AS_CYC - 11'h001;
            next_r.st     = H_SETUP;
          end
        end
      end
      H_SETUP: begin
        if (r.cnt == 11'h000) begin
          next_r.e   = 1'b1;
          next_r.cnt = PW_CYC - 11'h001;
          next_r.st  = H_EHIGH;
        end
      end
      H_EHIGH: begin
        if (r.cnt == 11'h000) begin
          next_r.e = 1'b0;
          if (r.rw) begin
            if (r.dl) begin
              next_r.rsp_data = db_s;
            end else if (!r.phase) begin
              next_r.hi_rd = db_s[`NIB_HI];
            end else begin
              next_r.rsp_data = {r.hi_rd, db_s[`NIB_HI]};
            end
          end
          next_r.cnt = HOLD_CYC - 11'h001;
          next_r.st  = H_EHOLD;
        end
      end
      H_EHOLD: begin
        if (r.cnt == 11'h000) begin
          if (!r.dl && !r.phase) begin
            next_r.phase  = 1'b1;
            next_r.db_out = place_nibble(r.dl, 1'b1, r.data);
            next_r.cnt    = AS_CYC - 11'h001;
            next_r.st     = H_SETUP;
          end else begin
            next_r.db_oe = 1'b0;
            if (r.rw) begin
              next_r.rsp_valid = 1'b1;
              next_r.st        = H_IDLE;
            end else begin
              if (is_function_set(r.rs, r.data)) begin
                next_r.dl = r.data[`FS_DL_BIT];
              end
              next_r.cnt = EXEC_CYC - 11'h001;
              next_r.st  = H_GAP;
            end
          end
        end
      end
      H_SER: begin
        if (r.cnt == 11'h000) begin
          next_r.cnt = HALF_CYC - 11'h001;
          if (!r.sclk) begin
            next_r.sclk = 1'b1;
          end else begin
            // Data moves only on the falling edge, half a period before the next sample.
            next_r.sclk = 1'b0;
            if (r.bits == 5'h01) begin
              next_r.serial_data_input = 1'b0;
              next_r.cnt = EXEC_CYC - 11'h001;
              next_r.st  = H_GAP;
            end else begin
              next_r.frame = {r.frame[25:0], 1'b0};
              next_r.serial_data_input   = r.frame[25];
              next_r.bits  = r.bits - 5'h01;
            end
          end
        end
      end
      H_GAP: begin
        if (r.cnt == 11'h000) begin
          next_r.st = H_IDLE; // [RULE_14]
        end
      end
      default: begin
        next_r.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r    <= '0;
      r.st <= H_IDLE;
      r.dl <= `DL_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign cmd_ready_o     = (r.st == H_IDLE);
  assign link.strap      = !r.serial;
  assign link.rs         = r.rs;
  assign link.rw         = r.rw;
  assign link.e          = r.e; // [RULE_04]
  assign link.db_host    = r.db_out;
  assign link.db_host_oe = r.db_oe;
  // Single device on the link, so chip select simply stays high.
  assign link.cs         = 1'b1; // [RULE_12]
  assign link.sclk       = r.sclk;
  assign link.serial_data_input        = r.serial_data_input;
  assign rsp_valid_o     = r.rsp_valid;
  assign rsp_data_o      = r.rsp_data;
  assign bus_width_o     = r.dl;
endmodule

//--- sim/lcd_port_sva.sv
`timescale 1ns/1ns
module lcd_port_sva (
  input wire logic       clk_i,
  input wire logic       arst_n_i,
  input wire logic       strap,
  input wire logic       rs,
  input wire logic       rw,
  input wire logic       e,
  input wire logic [7:0] db_host,
  input wire logic       db_host_oe,
  input wire logic       db_dev_oe,
  input wire logic       cs,
  input wire logic       sclk,
  input wire logic       serial_data_input
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic       sclk_q;
  logic [4:0] low_n;
  logic [4:0] bit_n;
  // A long low stretch restarts the bit count, so a frame with a lost or extra clock shows a wrong total at idle.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_q <= 1'b0;
      low_n  <= 5'h00;
      bit_n  <= 5'h00;
    end else begin
      sclk_q <= sclk;
      low_n  <= sclk ? 5'h00 : (low_n == 5'h1f ? low_n : low_n + 5'h01);
      if (sclk && !sclk_q) begin
        bit_n <= (low_n > 5'h10) ? 5'h01 : bit_n + 5'h01;
      end
    end
  end
  sequence sync_bit;
    $rose(sclk) ##1 (bit_n <= 5'h05);
  endsequence
  sequence pad_bit;
    $rose(sclk) ##1 (bit_n inside {[5'h08:5'h0b], [5'h10:5'h13], [5'h18:5'h1b]});
  endsequence
  chk_no_clash: assert property (!(db_host_oe && db_dev_oe)) else $error("data lines driven twice");
  chk_cs_tied: assert property (cs) else $error("select dropped");
  chk_e_width: assert property ($rose(e) |-> e [*8] ##1 e [*2] ##1 !e) else $error("strobe width");
  chk_ctrl_held: assert property (e |-> $stable(rs) && $stable(rw) && (rw || $stable(db_host)))
    else $error("control moved under strobe");
  chk_read_drive: assert property (db_dev_oe |-> rw && strap) else $error("device drives on write");
  chk_serial_no_e: assert property (!strap |-> !e) else $error("strobe in serial mode");
  chk_par_no_sclk: assert property (strap |-> !sclk) else $error("serial clock in parallel mode");
  chk_sclk_high: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk) else $error("serial clock width");
  chk_sid_steady: assert property (sclk |-> $stable(serial_data_input)) else $error("data moved while clock high");
  chk_sync_ones: assert property (sync_bit |-> serial_data_input) else $error("start run not ones");
  chk_pad_zeros: assert property (pad_bit |-> !serial_data_input) else $error("pad bit not zero");
  chk_write_only: assert property ($rose(sclk) ##1 (bit_n == 5'h06) |-> !serial_data_input) else $error("serial read");
  chk_frame_len: assert property (low_n == 5'h11 && bit_n != 5'h00 |-> bit_n == 5'h1b)
    else $error("frame length");
endmodule

//--- sim/test_lcd_ctrl_host_bus_port.sv
`timescale 1ns/1ns
module test_lcd_ctrl_host_bus_port;
  logic        clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        serial_mode_i, cmd_valid_i, cmd_rs_i, cmd_rw_i, busy_i;
  logic [7:0]  cmd_data_i, ram_data_i, wr_data, rsp_data, wr_data2, dv;
  logic [6:0]  addr_i;
  logic        wr_valid, wr_rs, refused, dev_bw, ser_mode, cmd_ready, rsp_valid, host_bw, wr_valid2, wr_rs2;
  logic [8:0]  exp_q[$], got2[$];
  logic [7:0]  rsp_q[$], pq[$];
  logic        sq[$];
  logic [26:0] fa;
  int          err_total = 0;
  int          n_checks = 0;
  int          ref_seen = 0;
  int          ref_exp = 0;
  int          w8 = 1;
  integer      seed = 32'hb502;
  lcd_host_if link ();
  lcd_host_if link2 ();
  lcd_port_host i_lcd_port_host (.clk_i(clk_i), .arst_n_i(arst_n_i), .link(link), .serial_mode_i(serial_mode_i),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready), .cmd_rs_i(cmd_rs_i), .cmd_rw_i(cmd_rw_i),
    .cmd_data_i(cmd_data_i), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .bus_width_o(host_bw));
  lcd_port_device i_lcd_port_device (.clk_i(clk_i), .arst_n_i(arst_n_i), .link(link), .busy_i(busy_i),
    .addr_i(addr_i), .ram_data_i(ram_data_i), .wr_valid_o(wr_valid), .wr_rs_o(wr_rs), .wr_data_o(wr_data),
    .refused_o(refused), .bus_width_o(dev_bw), .serial_mode_o(ser_mode));
  lcd_port_device i_lcd_port_device_2 (.clk_i(clk_i), .arst_n_i(arst_n_i), .link(link2), .busy_i(1'b0),
    .addr_i(7'h00), .ram_data_i(8'h00), .wr_valid_o(wr_valid2), .wr_rs_o(wr_rs2), .wr_data_o(wr_data2),
    .refused_o(), .bus_width_o(), .serial_mode_o());
  lcd_port_sva i_lcd_port_sva (.clk_i(clk_i), .arst_n_i(arst_n_i), .strap(link.strap), .rs(link.rs), .rw(link.rw),
    .e(link.e), .db_host(link.db_host), .db_host_oe(link.db_host_oe), .db_dev_oe(link.db_dev_oe), .cs(link.cs),
    .sclk(link.sclk), .serial_data_input(link.serial_data_input));
  always #25 clk_i = ~clk_i;
  always @(negedge link.e) if (link.rw === 1'b0) pq.push_back(link.db);
  always @(posedge link.sclk) sq.push_back(link.serial_data_input);
  always @(posedge clk_i) begin
    if (refused === 1'b1) ref_seen++;
    if (wr_valid2 === 1'b1) got2.push_back({wr_rs2, wr_data2});
    if (wr_valid === 1'b1) check({wr_rs, wr_data}, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
    if (rsp_valid === 1'b1) check(rsp_data, rsp_q.size() > 0 ? rsp_q.pop_front() : 'x);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t ns seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (err_total == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function automatic logic [26:0] frame(input logic rw, input logic rs, input logic [7:0] d);
    return {5'h1f, rw, rs, 4'h0, d[7:4], 4'h0, d[3:0], 4'h0};
  endfunction
  task automatic cmd(input logic ser, input logic rs, input logic rw, input logic bsy, input logic [7:0] d);
    logic [6:0]  a;
    logic [7:0]  m;
    logic [26:0] got;
    int          n;
    a = 7'($random(seed));
    m = 8'($random(seed));
    got = '0;
    n = 0;
    pq.delete();
    sq.delete();
    if (!rw && bsy) ref_exp++;
    else if (!rw) exp_q.push_back({rs, d});
    else if (!ser) rsp_q.push_back(rs ? m : {1'b0, a});
    @(posedge clk_i);
    {serial_mode_i, cmd_rs_i, cmd_rw_i, busy_i, cmd_valid_i} <= {ser, rs, rw, bsy, 1'b1};
    {cmd_data_i, addr_i, ram_data_i} <= {d, a, m};
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    @(negedge clk_i);
    while (cmd_ready !== 1'b1 && n < 4000) begin
      @(negedge clk_i);
      n++;
    end
    // The read answer comes with ready and is checked on the next rising edge, and the strap needs three cycles to cross, so wait before looking.
    repeat (4) @(negedge clk_i);
    check(n < 4000, 1);
    if (ser && rw) check(sq.size() + pq.size(), 0);
    if (ser && !rw) begin
      foreach (sq[i]) got = {got[25:0], sq[i]};
      check(sq.size(), 27);
      check(got, frame(rw, rs, d));
    end
    if (!ser && !rw) begin
      check(pq.size(), w8 ? 1 : 2);
      if (w8) check(pq[0], d);
      else check({pq[0], pq[1]}, {d[7:4], 4'h0, d[3:0], 4'h0});
      if (!bsy && !rs && d[7:5] == 3'h1) w8 = d[4];
    end
    if (!ser) check({host_bw, dev_bw}, {w8[0], w8[0]});
    check(ser_mode, ser);
    check(exp_q.size() + rsp_q.size(), 0);
    check(ref_seen, ref_exp);
  endtask
  // The second device sees a host that breaks framing on purpose; its 32 ns serial clock rests low between frames.
  task automatic sbits(input logic [26:0] v, input int nb);
    for (int i = 26; i > 26 - nb; i--) begin
      link2.serial_data_input <= v[i];
      #16 link2.sclk <= 1'b1;
      #16 link2.sclk <= 1'b0;
    end
  endtask
  initial begin
    {serial_mode_i, cmd_valid_i, cmd_rs_i, cmd_rw_i, busy_i, cmd_data_i, addr_i, ram_data_i} = '0;
    {link2.strap, link2.rs, link2.rw, link2.e, link2.db_host_oe, link2.sclk, link2.serial_data_input, link2.db_host} = '0;
    link2.cs = 1'b1;
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(negedge clk_i);
    check({ser_mode, host_bw, dev_bw, cmd_ready}, 4'h7);
    for (int i = 0; i < 4; i++) cmd(1'b0, i[0], 1'b0, 1'b0, 8'h80 | 8'($random(seed)));
    for (int i = 0; i < 2; i++) cmd(1'b0, i[0], 1'b1, 1'b0, 8'h00);
    // The host cannot see the busy level and takes the width of any function set, so the refused one keeps eight lines.
    cmd(1'b0, 1'b0, 1'b0, 1'b1, 8'h30);
    cmd(1'b0, 1'b0, 1'b0, 1'b0, 8'h20);
    for (int i = 0; i < 3; i++) cmd(1'b0, i[0], 1'b0, 1'b0, 8'h80 | 8'($random(seed)));
    for (int i = 0; i < 2; i++) cmd(1'b0, i[0], 1'b1, 1'b0, 8'h00);
    cmd(1'b0, 1'b1, 1'b0, 1'b1, 8'($random(seed)));
    cmd(1'b0, 1'b0, 1'b0, 1'b0, 8'h30);
    cmd(1'b0, 1'b1, 1'b0, 1'b0, 8'($random(seed)));
    cmd(1'b1, 1'b1, 1'b1, 1'b0, 8'($random(seed)));
    for (int i = 0; i < 3; i++) cmd(1'b1, 1'b1, 1'b0, 1'b0, 8'($random(seed)));
    cmd(1'b1, 1'b1, 1'b0, 1'b1, 8'($random(seed)));
    fa = frame(1'b0, 1'b1, 8'($random(seed)));
    dv = 8'($random(seed));
    @(posedge clk_i);
    sbits(fa, 20);
    link2.cs <= 1'b0;
    repeat (4) @(posedge clk_i);
    sbits(fa << 20, 7);
    link2.cs <= 1'b1;
    repeat (4) @(posedge clk_i);
    sbits(fa << 20, 7);
    sbits({3'h2, 24'h00_0000}, 3);
    sbits(frame(1'b0, 1'b1, dv), 27);
    repeat (20) @(posedge clk_i);
    check(got2.size(), 1);
    check(got2[0], {1'b1, dv});
    end_sim();
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    err_total++;
    end_sim();
  end
endmodule
